// [hw/mfc_flow_ctrl.sv]
// Summary of operation
// [RULE_01] Pause duration field goes into sent pause frames
// [RULE_02] Enabled flow control honours received pause frames
// [RULE_03] Writing busy bit one sends one pause
// [RULE_04] Busy bit clears after pause frame sent
// [RULE_05] Software waits for busy zero before requesting
// [RULE_06] Frames above maximum size count as long
// [RULE_07] Software writes one to control bit one
// [RULE_08] Software fills first reserved word with ones
// [RULE_09] Software fills second reserved word with ones
// [RULE_10] Received frame counter wraps, cleared by reset
// [RULE_11] Pause waits for current frame, resumes automatically
`timescale 1ns/1ps
`default_nettype none
module mfc_flow_ctrl (
  input  wire logic                clk_sys,
  input  wire logic                srst,
  input  wire logic                ce,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata_ff,
  input  wire mfc_pkg::mfc_rx_evt_t rx_evt,
  input  wire mfc_pkg::mfc_tx_evt_t tx_evt,
  output logic                     tx_pause_req_ff,
  output logic      [15:0]         tx_pause_time_ff,
  output logic                     tx_hold_ff,
  output logic                     long_frame_ff
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [15:0]         pause_dur_ff;
  logic                fce_ff;
  logic [10:0]         max_frame_ff;
  logic                cc_rsv_ff;
  logic [31:0]         rsv_a_ff;
  logic [31:0]         rsv_b_ff;
  logic [31:0]         rx_frames_ff;
  logic [31:0]         long_frames_ff;
  mfc_pkg::mfc_state_t state_ff;
  mfc_pkg::mfc_state_t nxt_state;
  logic                busy;
  logic                wr_flow;
  logic                start_req;
  logic                pause_load;
  logic                paused;
  logic                is_long;
  logic [31:0]         nxt_rdata;

  assign wr_flow   = reg_wr && hit(reg_addr, mfc_pkg::OFS_FLOW_CTRL);
  assign start_req = wr_flow && reg_wdata[mfc_pkg::FCB_BIT];
  assign busy      = (state_ff != mfc_pkg::MFC_IDLE);

  // Flow control register fields
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pause_dur_ff <= mfc_pkg::RST_PAUSE_DUR;
      fce_ff       <= mfc_pkg::RST_FCE;
    end else if (ce && wr_flow) begin
      pause_dur_ff <= reg_wdata[mfc_pkg::PT_LSB +: mfc_pkg::PT_W];
      fce_ff       <= reg_wdata[mfc_pkg::FCE_BIT];
    end
  end

  // Counter control register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      max_frame_ff <= mfc_pkg::RST_MAX_FRAME;
      cc_rsv_ff    <= mfc_pkg::RST_CC_RSV;
    end else if (ce && reg_wr && hit(reg_addr, mfc_pkg::OFS_CNT_CTRL)) begin
      max_frame_ff <= reg_wdata[mfc_pkg::MXF_LSB +: mfc_pkg::MXF_W];
      cc_rsv_ff    <= reg_wdata[mfc_pkg::CC_RSV_BIT]; // [RULE_07]
    end
  end

  // Reserved control words, plain storage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsv_a_ff <= mfc_pkg::RST_RSV_WORD;
    end else if (ce && reg_wr && hit(reg_addr, mfc_pkg::OFS_RSV_A)) begin
      rsv_a_ff <= reg_wdata; // [RULE_08]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsv_b_ff <= mfc_pkg::RST_RSV_WORD;
    end else if (ce && reg_wr && hit(reg_addr, mfc_pkg::OFS_RSV_B)) begin
      rsv_b_ff <= reg_wdata; // [RULE_09]
    end
  end

  // Pause frame transmit sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mfc_pkg::MFC_IDLE: begin
        if (start_req) begin
          nxt_state = mfc_pkg::MFC_REQ; // [RULE_03]
        end
      end
      mfc_pkg::MFC_REQ: begin
        if (tx_evt.pause_done) begin
          nxt_state = mfc_pkg::MFC_IDLE; // [RULE_04]
        end else if (tx_evt.pause_start) begin
          nxt_state = mfc_pkg::MFC_SEND;
        end
      end
      mfc_pkg::MFC_SEND: begin
        if (tx_evt.pause_done) begin
          nxt_state = mfc_pkg::MFC_IDLE; // [RULE_04]
        end
      end
      default: begin
        nxt_state = mfc_pkg::MFC_IDLE;
      end
    endcase
    // Request in the completion cycle is not lost
    if (tx_evt.pause_done && start_req) begin
      nxt_state = mfc_pkg::MFC_REQ; // [RULE_03] [RULE_05]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff <= mfc_pkg::MFC_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Pause request and duration toward the transmitter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_pause_req_ff  <= 1'b0;
      tx_pause_time_ff <= mfc_pkg::RST_PAUSE_DUR;
    end else if (ce) begin
      tx_pause_req_ff  <= (nxt_state == mfc_pkg::MFC_REQ);
      tx_pause_time_ff <= pause_dur_ff; // [RULE_01]
    end
  end

  // Received pause frames load the hold timer
  assign pause_load = fce_ff && rx_evt.frame_end && rx_evt.is_pause; // [RULE_02]

  mfc_pause_timer u_timer (
    .clk_sys (clk_sys),
    .srst    (srst),
    .ce      (ce),
    .load    (pause_load),
    .quanta  (rx_evt.quanta),
    .paused  (paused)
  );

  // Hold only between frames, release when the timer expires
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_hold_ff <= 1'b0;
    end else if (ce) begin
      tx_hold_ff <= fce_ff && paused && (tx_hold_ff || !tx_evt.in_frame); // [RULE_02] [RULE_11]
    end
  end

  // Received frame counter, free running with wrap
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_frames_ff <= mfc_pkg::RST_COUNTER;
    end else if (ce && rx_evt.frame_end) begin
      rx_frames_ff <= rx_frames_ff + 32'h00000001; // [RULE_10]
    end
  end

  // Long transmitted frame classification
  assign is_long = tx_evt.frame_end && (tx_evt.frame_len > {5'h00, max_frame_ff});

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      long_frames_ff <= mfc_pkg::RST_COUNTER;
      long_frame_ff  <= 1'b0;
    end else if (ce) begin
      long_frame_ff <= is_long; // [RULE_06]
      if (is_long) begin
        long_frames_ff <= long_frames_ff + 32'h00000001; // [RULE_06]
      end
    end
  end

  // Read data mux, unmapped offsets read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (hit(reg_addr, mfc_pkg::OFS_FLOW_CTRL)) begin
      nxt_rdata[mfc_pkg::PT_LSB +: mfc_pkg::PT_W] = pause_dur_ff;
      nxt_rdata[mfc_pkg::FCE_BIT] = fce_ff;
      nxt_rdata[mfc_pkg::FCB_BIT] = busy; // [RULE_03]
    end else if (hit(reg_addr, mfc_pkg::OFS_CNT_CTRL)) begin
      nxt_rdata[mfc_pkg::MXF_LSB +: mfc_pkg::MXF_W] = max_frame_ff;
      nxt_rdata[mfc_pkg::CC_RSV_BIT] = cc_rsv_ff;
    end else if (hit(reg_addr, mfc_pkg::OFS_RSV_A)) begin
      nxt_rdata = rsv_a_ff;
    end else if (hit(reg_addr, mfc_pkg::OFS_RSV_B)) begin
      nxt_rdata = rsv_b_ff;
    end else if (hit(reg_addr, mfc_pkg::OFS_LONG_FRAMES)) begin
      nxt_rdata = long_frames_ff;
    end else if (hit(reg_addr, mfc_pkg::OFS_RX_FRAMES)) begin
      nxt_rdata = rx_frames_ff;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_ff <= 32'h00000000;
    end else if (ce) begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
    end
  end

endmodule : mfc_flow_ctrl
`default_nettype wire

// [hw/mfc_pause_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module mfc_pause_timer (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] quanta,
  output logic             paused
);

  logic [8:0]  slot_cnt_ff;
  logic [15:0] quanta_cnt_ff;

  // Slot and quanta countdown; a new pause frame reloads, zero ends the pause
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slot_cnt_ff   <= 9'h000;
      quanta_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (load) begin
        slot_cnt_ff   <= 9'h000;
        quanta_cnt_ff <= quanta;
      end else if (quanta_cnt_ff != 16'h0000) begin
        if (slot_cnt_ff == mfc_pkg::SLOT_LAST) begin
          slot_cnt_ff   <= 9'h000;
          quanta_cnt_ff <= quanta_cnt_ff - 16'h0001;
        end else begin
          slot_cnt_ff <= slot_cnt_ff + 9'h001;
        end
      end
    end
  end

  assign paused = (quanta_cnt_ff != 16'h0000);

endmodule : mfc_pause_timer
`default_nettype wire

// [inc/mfc_pkg.sv]
`default_nettype none
package mfc_pkg;

  // Register offsets
  localparam logic [11:0] OFS_FLOW_CTRL   = 12'h01C;
  localparam logic [11:0] OFS_CNT_CTRL    = 12'h100;
  localparam logic [11:0] OFS_RSV_A       = 12'h10C;
  localparam logic [11:0] OFS_RSV_B       = 12'h110;
  localparam logic [11:0] OFS_LONG_FRAMES = 12'h120;
  localparam logic [11:0] OFS_RX_FRAMES   = 12'h200;

  // Field positions
  localparam int unsigned FCB_BIT    = 0;
  localparam int unsigned FCE_BIT    = 1;
  localparam int unsigned PT_LSB     = 16;
  localparam int unsigned PT_W       = 16;
  localparam int unsigned MXF_LSB    = 3;
  localparam int unsigned MXF_W      = 11;
  localparam int unsigned CC_RSV_BIT = 1;

  // Values after reset
  localparam logic [15:0] RST_PAUSE_DUR = 16'h0050;
  localparam logic        RST_FCE       = 1'b1;
  localparam logic [10:0] RST_MAX_FRAME = 11'h5E0;
  localparam logic        RST_CC_RSV    = 1'b0;
  localparam logic [31:0] RST_RSV_WORD  = 32'h00000000;
  localparam logic [31:0] RST_COUNTER   = 32'h00000000;

  // Timing: one pause slot is 512 bit times at 100 Mbit/s
  localparam int unsigned CLK_NS   = 20;
  localparam int unsigned SLOT_NS  = 5120;
  localparam int unsigned SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0]  SLOT_LAST = 9'(SLOT_CYC - 1);

  // Received frame event from the MAC receiver
  typedef struct packed {
    logic        frame_end;
    logic        is_pause;
    logic [15:0] quanta;
  } mfc_rx_evt_t;

  // Status from the MAC transmitter
  typedef struct packed {
    logic        in_frame;
    logic        frame_end;
    logic [15:0] frame_len;
    logic        pause_start;
    logic        pause_done;
  } mfc_tx_evt_t;

  // Pause frame transmit sequencer
  typedef enum logic [1:0] {
    MFC_IDLE = 2'b00,
    MFC_REQ  = 2'b01,
    MFC_SEND = 2'b11
  } mfc_state_t;

endpackage : mfc_pkg
`default_nettype wire

// [test/mfc_flow_ctrl_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module mfc_fc_checker (
  input wire logic                 clk_sys,
  input wire logic                 srst,
  input wire logic                 ce,
  input wire logic [11:0]          reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata_ff,
  input wire mfc_pkg::mfc_rx_evt_t rx_evt,
  input wire mfc_pkg::mfc_tx_evt_t tx_evt,
  input wire logic                 tx_pause_req_ff,
  input wire logic [15:0]          tx_pause_time_ff,
  input wire logic                 tx_hold_ff,
  input wire logic                 long_frame_ff
);
  logic        en_ff;
  logic [10:0] mx_ff;
  logic        fc_wr;
  logic        long_exp;
  logic        rx_pz;
  assign fc_wr = ce && reg_wr && reg_addr == mfc_pkg::OFS_FLOW_CTRL;
  assign long_exp = tx_evt.frame_end && tx_evt.frame_len > {5'h00, mx_ff};
  assign rx_pz = rx_evt.frame_end && rx_evt.is_pause && en_ff && !tx_evt.in_frame;
  // Mirrors enable and size limit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_ff <= mfc_pkg::RST_FCE;
      mx_ff <= mfc_pkg::RST_MAX_FRAME;
    end else begin
      if (fc_wr) en_ff <= reg_wdata[1];
      if (ce && reg_wr && reg_addr == mfc_pkg::OFS_CNT_CTRL) mx_ff <= reg_wdata[13:3];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (
    ce && !reg_rd |=> reg_rdata_ff == 32'h0) else $error("read data outside slot");
  a_req_start: assert property (
    fc_wr && reg_wdata[0] && !tx_pause_req_ff |=> tx_pause_req_ff) else $error("no request");
  a_req_end: assert property (
    tx_pause_req_ff && (tx_evt.pause_start || tx_evt.pause_done) && !fc_wr
    |=> !tx_pause_req_ff) else $error("request stuck");
  a_time_copy: assert property (
    fc_wr ##1 !fc_wr |=> {16'h0, tx_pause_time_ff} == $past(reg_wdata, 2) >> 16)
    else $error("pause time wrong");
  a_hold_rise: assert property (
    rx_pz && rx_evt.quanta != 16'h0 |-> ##2 tx_hold_ff) else $error("hold late");
  a_hold_span: assert property (
    rx_pz && rx_evt.quanta == 16'h1 |-> ##257 tx_hold_ff ##1 !tx_hold_ff)
    else $error("hold length wrong");
  a_hold_wait: assert property (
    tx_evt.in_frame && !tx_hold_ff |=> !tx_hold_ff) else $error("hold cut a frame");
  a_long_flag: assert property (
    ce |=> long_frame_ff == $past(long_exp)) else $error("long flag wrong");
endmodule : mfc_fc_checker
bind mfc_flow_ctrl mfc_fc_checker u_mfc_fc_checker (.*);
`default_nettype wire

// [test/mfc_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mfc_mac_model (
  input wire logic                  clk_sys,
  input wire logic                  tx_pause_req_ff,
  input wire logic                  tx_hold_ff,
  output var mfc_pkg::mfc_rx_evt_t rx_evt,
  output var mfc_pkg::mfc_tx_evt_t tx_evt
);
  int slow = 0;
  initial rx_evt = '0;
  initial tx_evt = '0;
  // Sends the requested pause frame
  always @(posedge clk_sys) begin
    if (tx_pause_req_ff) begin
      repeat (slow) @(posedge clk_sys);
      tx_evt.pause_start <= 1'b1;
      @(posedge clk_sys);
      tx_evt.pause_start <= 1'b0;
      repeat (slow + 3) @(posedge clk_sys);
      tx_evt.pause_done <= 1'b1;
      @(posedge clk_sys);
      tx_evt.pause_done <= 1'b0;
    end
  end
  task automatic send_tx(input logic [15:0] len, input int dur);
    while (tx_hold_ff) @(posedge clk_sys);
    tx_evt.in_frame <= 1'b1;
    repeat (dur) @(posedge clk_sys);
    tx_evt.in_frame <= 1'b0;
    tx_evt.frame_end <= 1'b1;
    tx_evt.frame_len <= len;
    @(posedge clk_sys);
    tx_evt.frame_end <= 1'b0;
    tx_evt.frame_len <= ~len;
  endtask : send_tx
  task automatic recv(input logic pz, input logic [15:0] q);
    rx_evt <= '{1'b1, pz, q};
    @(posedge clk_sys);
    rx_evt <= '{1'b0, 1'b0, ~q};
    @(posedge clk_sys);
  endtask : recv
endmodule : mfc_mac_model
`default_nettype wire

// [test/tb_mfc_flow_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_mfc_flow_ctrl;
  localparam logic [11:0] FC = mfc_pkg::OFS_FLOW_CTRL;
  localparam logic [11:0] CC = mfc_pkg::OFS_CNT_CTRL;
  localparam logic [11:0] RX = mfc_pkg::OFS_RX_FRAMES;
  logic                 clk_sys = 1'b0;
  logic                 srst = 1'b1;
  logic                 ce = 1'b1;
  logic [11:0]          reg_addr = 12'h000;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_rdata_ff;
  mfc_pkg::mfc_rx_evt_t rx_evt;
  mfc_pkg::mfc_tx_evt_t tx_evt;
  logic                 tx_pause_req_ff;
  logic [15:0]          tx_pause_time_ff;
  logic                 tx_hold_ff;
  logic                 long_frame_ff;
  int                   bad_count = 0;
  int                   checks = 0;
  int                   cyc = 0;
  int                   n;
  int                   lc = 0;
  logic [31:0]          d;
  logic [15:0]          len;
  logic [10:0]          mx;
  always #10 clk_sys = ~clk_sys;
  mfc_flow_ctrl u_mfc_flow_ctrl (.*);
  mfc_mac_model u_mfc_mac_model (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata_ff;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rdc
  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    d = $urandom(42613);
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdc(FC, {mfc_pkg::RST_PAUSE_DUR, 14'h0, mfc_pkg::RST_FCE, 1'b0});
    rdc(CC, {18'h0, mfc_pkg::RST_MAX_FRAME, 3'h0});
    rdc(mfc_pkg::OFS_RSV_B, mfc_pkg::RST_RSV_WORD);
    wr(mfc_pkg::OFS_RSV_A, 32'hFFFFFFFF);
    wr(mfc_pkg::OFS_RSV_B, 32'hFFFFFFFF);
    rdc(mfc_pkg::OFS_RSV_A, 32'hFFFFFFFF);
    rdc(mfc_pkg::OFS_RSV_B, 32'hFFFFFFFF);
    wr(RX, 32'h12345678);
    rdc(RX, 32'h0);
    rdc(12'h3FC, 32'h0);
    mx = 11'($urandom_range(80, 2000));
    wr(CC, {18'h0, mx, 3'h2});
    rdc(CC, {18'h0, mx, 3'h2});
    ce <= 1'b0;
    wr(CC, 32'h00003FFA);
    u_mfc_mac_model.recv(1'b0, 16'h0000);
    ce <= 1'b1;
    rdc(CC, {18'h0, mx, 3'h2});
    for (int s = 0; s < 2; s++) begin
      u_mfc_mac_model.slow = s * 5;
      len = 16'($urandom);
      wr(FC, {len, 16'h0003});
      rdc(FC, {len, 16'h0003});
      chk({16'h0, tx_pause_time_ff}, {16'h0, len});
      n = 0;
      do begin
        rd(FC);
        n++;
      end while (d[0] && n < 20);
      chk(d, {len, 16'h0002});
    end
    u_mfc_mac_model.recv(1'b1, 16'h0001);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, tx_hold_ff}, 32'h1);
    repeat (270) @(posedge clk_sys);
    chk({31'h0, tx_hold_ff}, 32'h0);
    fork
      u_mfc_mac_model.send_tx(16'h0040, 10);
      begin
        repeat (3) @(posedge clk_sys);
        u_mfc_mac_model.recv(1'b1, 16'h0002);
      end
    join
    repeat (3) @(posedge clk_sys);
    chk({31'h0, tx_hold_ff}, 32'h1);
    u_mfc_mac_model.send_tx(16'h0046, 2);
    chk({31'h0, tx_hold_ff}, 32'h0);
    wr(FC, 32'h00500000);
    u_mfc_mac_model.recv(1'b1, 16'h0001);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, tx_hold_ff}, 32'h0);
    n = $urandom_range(3, 12);
    repeat (n) u_mfc_mac_model.recv(1'($urandom), 16'($urandom));
    rdc(RX, 32'(n + 3));
    for (int i = 0; i < 8; i++) begin
      len = (i < 2) ? 16'(mx) + 16'(i) : 16'($urandom_range(1, 2100));
      u_mfc_mac_model.send_tx(len, 2);
      lc += int'(len > 16'(mx));
    end
    rdc(mfc_pkg::OFS_LONG_FRAMES, 32'(lc));
    tally_and_finish();
  end
endmodule : tb_mfc_flow_ctrl
`default_nettype wire
